//--- logic/cpb_pkg.sv
//----------------------------------------------------------------------
// Functional notes
// - Registers reachable only in config state, matching index
// - Identity register read only, fixed code
// - Revision register read only, current revision
// - Three test registers read/write, clear on power-on
// - Low base register holds address bits 7:0
// - High base register holds bits 10:8, rest reserved
// - Decode needs address bits 15:11 all zero
// - Base even; low base bit 0 reads zero
// - Base loads from strap on both resets
// - High base write switches decoder to new base
// - UART2 mode set by field or infrared engine
// - Reserved mode codes select infrared alternate mode
//----------------------------------------------------------------------
// Purpose : Constants and carrier types of the config port register group
// Assumes : Byte wide I/O cycles, 16 bit I/O address
// Notes   : Index values are the selection codes loaded into the index port
//----------------------------------------------------------------------
package cpb_pkg;

   //---------------------------------------------------------------
   // Selection index values
   //---------------------------------------------------------------
   localparam logic [7:0] CPB_IDX_UART_MODE  = 8'h0C;
   localparam logic [7:0] CPB_IDX_DEV_ID     = 8'h0D;
   localparam logic [7:0] CPB_IDX_REVISION   = 8'h0E;
   localparam logic [7:0] CPB_IDX_TEST_ONE   = 8'h0F;
   localparam logic [7:0] CPB_IDX_TEST_TWO   = 8'h10;
   localparam logic [7:0] CPB_IDX_TEST_THREE = 8'h11;
   localparam logic [7:0] CPB_IDX_BASE_LOW   = 8'h12;
   localparam logic [7:0] CPB_IDX_BASE_HIGH  = 8'h13;

   //---------------------------------------------------------------
   // Reset values
   //---------------------------------------------------------------
   localparam logic [7:0] CPB_INDEX_RST      = 8'h00;
   localparam logic [7:0] CPB_TEST_RST       = 8'h00;
   localparam logic [7:0] CPB_BASE_LOW_STRAP0 = 8'h2E;
   localparam logic [7:0] CPB_BASE_LOW_STRAP1 = 8'h4E;
   localparam logic [7:0] CPB_BASE_HIGH_RST  = 8'h00;
   localparam logic [7:0] CPB_UART_MODE_RST  = 8'h02;
   localparam logic [7:0] CPB_RDATA_RST      = 8'h00;

   //---------------------------------------------------------------
   // Field layouts
   //---------------------------------------------------------------
   localparam logic [7:0] CPB_BASE_LOW_MASK  = 8'hFE;
   localparam logic [7:0] CPB_BASE_HIGH_MASK = 8'h07;
   localparam int         CPB_MODE_LSB       = 3;
   localparam int         CPB_MODE_MSB       = 5;
   localparam logic [2:0] CPB_MODE_ALT_CODE  = 3'h3;

   //---------------------------------------------------------------
   // Timing: cycles from reset release to strap capture
   //---------------------------------------------------------------
   localparam logic [1:0] CPB_STRAP_WAIT     = 2'h3;

   //---------------------------------------------------------------
   // Carrier types
   //---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } cpb_io_req_t;

   typedef struct packed {
      logic [7:0]      index;
      logic [2:0][7:0] test;
      logic [7:0]      base_low;
      logic [7:0]      base_high;
      logic [10:0]     dec_base;
      logic [7:0]      uart_mode;
      logic [7:0]      rdata;
      logic            rvalid;
      logic [1:0]      strap_wait;
   } cpb_state_t;

endpackage : cpb_pkg

//--- logic/cpb_sync.sv
//----------------------------------------------------------------------
// Purpose : Two flip-flop synchroniser for a level from a pin
// Assumes : Input is a slow level, no glitch filtering needed
// Notes   : First stage feeds only the second stage
//----------------------------------------------------------------------
`timescale 1ns/10ps
module cpb_sync (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic pin_in,
   output logic      level_out
);

   typedef struct packed {
      logic meta;
      logic level;
   } cpb_sync_state_t;

   cpb_sync_state_t sync_q;
   cpb_sync_state_t sync_d;

   // Next stage values; only the second stage reads the first
   always_comb begin
      sync_d.meta  = pin_in;
      sync_d.level = sync_q.meta;
   end

   // Two stage capture
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync_q.meta  <= 1'b0;
         sync_q.level <= 1'b0;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign level_out = sync_q.level;

endmodule : cpb_sync

//--- logic/cpb_decode.sv
//----------------------------------------------------------------------
// Purpose : Address decoder for the index and data configuration ports
// Assumes : Base held even, bits 15:11 of a valid port address zero
// Notes   : Purely combinational
//----------------------------------------------------------------------
`timescale 1ns/10ps
module cpb_decode (
   input  wire logic [15:0] io_addr,
   input  wire logic [10:0] port_base,
   output logic             hit_index,
   output logic             hit_data
);

   logic pair_hit;

   // Upper bits zero and pair match, bit 0 picks the port
   assign pair_hit  = (io_addr[15:11] == 5'h00) &&
                      (io_addr[10:1] == port_base[10:1]);
   assign hit_index = pair_hit && !io_addr[0];
   assign hit_data  = pair_hit && io_addr[0];

endmodule : cpb_decode

//--- logic/cpb_top.sv
//----------------------------------------------------------------------
// Purpose : Config port base and identity register group
// Assumes : I/O strobes are one cycle pulses on ref_clk
// Notes   : Base address is captured from the strap after reset release
//----------------------------------------------------------------------
`timescale 1ns/10ps
module cpb_top #(
   parameter logic [7:0] DEVICE_CODE   = 8'hA5, // Arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h03  // Arbitrary value
) (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 hard_rst,
   input  wire logic                 cfg_state,
   input  wire logic                 base_address_strap,
   input  wire cpb_pkg::cpb_io_req_t io_req,
   input  wire logic                 fir_mode_wr,
   input  wire logic [2:0]           fir_mode,
   output logic [7:0]                io_rdata,
   output logic                      io_rvalid,
   output logic [10:0]               cfg_port_base,
   output logic [2:0]                uart2_mode,
   output logic                      ir_alt_mode
);

   //---------------------------------------------------------------
   // Signals
   //---------------------------------------------------------------
   cpb_pkg::cpb_state_t st_q;
   cpb_pkg::cpb_state_t st_d;
   logic                strap_level;
   logic                hit_index;
   logic                hit_data;
   logic [7:0]          strap_low;

   //---------------------------------------------------------------
   // Read mux
   //---------------------------------------------------------------
   function automatic logic [7:0] reg_read(
      input logic [7:0]          idx,
      input cpb_pkg::cpb_state_t s
   );
      logic [7:0] val;
      val = 8'h00;
      case (idx)
         cpb_pkg::CPB_IDX_UART_MODE:  val = s.uart_mode;
         cpb_pkg::CPB_IDX_DEV_ID:     val = DEVICE_CODE;
         cpb_pkg::CPB_IDX_REVISION:   val = REVISION_CODE;
         cpb_pkg::CPB_IDX_TEST_ONE:   val = s.test[0];
         cpb_pkg::CPB_IDX_TEST_TWO:   val = s.test[1];
         cpb_pkg::CPB_IDX_TEST_THREE: val = s.test[2];
         cpb_pkg::CPB_IDX_BASE_LOW:   val = s.base_low & cpb_pkg::CPB_BASE_LOW_MASK;
         cpb_pkg::CPB_IDX_BASE_HIGH:  val = s.base_high & cpb_pkg::CPB_BASE_HIGH_MASK;
         default:                     val = 8'h00;
      endcase
      return val;
   endfunction : reg_read

   //---------------------------------------------------------------
   // Strap synchroniser and port decoder
   //---------------------------------------------------------------
   cpb_sync u_sync (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .pin_in    (base_address_strap),
      .level_out (strap_level)
   );

   cpb_decode u_decode (
      .io_addr   (io_req.addr),
      .port_base (st_q.dec_base),
      .hit_index (hit_index),
      .hit_data  (hit_data)
   );

   // Strap selects the power-up low byte
   assign strap_low = strap_level ? cpb_pkg::CPB_BASE_LOW_STRAP1
                                  : cpb_pkg::CPB_BASE_LOW_STRAP0;

   //---------------------------------------------------------------
   // Next state
   //---------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      st_d.rvalid = 1'b0;

      // Strap capture after reset release
      if (st_q.strap_wait != 2'h0) begin
         st_d.strap_wait = st_q.strap_wait - 2'h1;
         if (st_q.strap_wait == 2'h1) begin
            st_d.base_low  = strap_low;
            st_d.base_high = cpb_pkg::CPB_BASE_HIGH_RST;
            st_d.dec_base  = {3'h0, strap_low};
         end
      end

      // Infrared engine block control sets the mode field
      if (fir_mode_wr) begin
         st_d.uart_mode[cpb_pkg::CPB_MODE_MSB:cpb_pkg::CPB_MODE_LSB] = fir_mode;
      end

      if (hard_rst) begin
         // Hard reset reloads base from strap, keeps test registers
         st_d.base_low  = strap_low;
         st_d.base_high = cpb_pkg::CPB_BASE_HIGH_RST;
         st_d.dec_base  = {3'h0, strap_low};
         st_d.uart_mode = cpb_pkg::CPB_UART_MODE_RST;
         st_d.index     = cpb_pkg::CPB_INDEX_RST;
      end else if (cfg_state && io_req.wr && hit_index) begin
         st_d.index = io_req.wdata;
      end else if (cfg_state && io_req.wr && hit_data) begin
         // Data port write lands only on the selected register
         case (st_q.index)
            cpb_pkg::CPB_IDX_UART_MODE: begin
               st_d.uart_mode = io_req.wdata;
            end
            cpb_pkg::CPB_IDX_TEST_ONE: begin
               st_d.test[0] = io_req.wdata;
            end
            cpb_pkg::CPB_IDX_TEST_TWO: begin
               st_d.test[1] = io_req.wdata;
            end
            cpb_pkg::CPB_IDX_TEST_THREE: begin
               st_d.test[2] = io_req.wdata;
            end
            cpb_pkg::CPB_IDX_BASE_LOW: begin
               // Held only; decoder waits for the high write
               st_d.base_low = io_req.wdata & cpb_pkg::CPB_BASE_LOW_MASK;
            end
            cpb_pkg::CPB_IDX_BASE_HIGH: begin
               st_d.base_high = io_req.wdata & cpb_pkg::CPB_BASE_HIGH_MASK;
               st_d.dec_base  = {io_req.wdata[2:0], st_q.base_low};
            end
            default: begin
               st_d.index = st_q.index;                        // Identity, revision: no effect
            end
         endcase
      end

      // Reads answer one cycle later, only in config state
      if (!hard_rst && cfg_state && io_req.rd && (hit_index || hit_data)) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = hit_index ? st_q.index : reg_read(st_q.index, st_q);
      end
   end

   //---------------------------------------------------------------
   // State register
   //---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_q.index      <= cpb_pkg::CPB_INDEX_RST;
         st_q.test[0]    <= cpb_pkg::CPB_TEST_RST;
         st_q.test[1]    <= cpb_pkg::CPB_TEST_RST;
         st_q.test[2]    <= cpb_pkg::CPB_TEST_RST;
         st_q.base_low   <= cpb_pkg::CPB_BASE_LOW_STRAP0;
         st_q.base_high  <= cpb_pkg::CPB_BASE_HIGH_RST;
         st_q.dec_base   <= {3'h0, cpb_pkg::CPB_BASE_LOW_STRAP0};
         st_q.uart_mode  <= cpb_pkg::CPB_UART_MODE_RST;
         st_q.rdata      <= cpb_pkg::CPB_RDATA_RST;
         st_q.rvalid     <= 1'b0;
         st_q.strap_wait <= cpb_pkg::CPB_STRAP_WAIT;
      end else begin
         st_q <= st_d;
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------
   assign io_rdata      = st_q.rdata;
   assign io_rvalid     = st_q.rvalid;
   assign cfg_port_base = st_q.dec_base;
   assign uart2_mode    = st_q.uart_mode[cpb_pkg::CPB_MODE_MSB:cpb_pkg::CPB_MODE_LSB];
   // Reserved mode codes drive the infrared alternate mode
   assign ir_alt_mode   = uart2_mode[2] || (uart2_mode == cpb_pkg::CPB_MODE_ALT_CODE);

endmodule : cpb_top

//--- logic/cpb_top_dummy_placeholder_removed.sv
//----------------------------------------------------------------------
// Purpose : Intentionally empty
// Assumes : Nothing
// Notes   : Holds no logic
//----------------------------------------------------------------------

//--- tb/cpb_top_assertions.sv
//----------------------------------------------------------------------
// Purpose : Port level checks of the config port register group
// Assumes : Index port tracked here from accepted host writes
// Notes   : Bound to cpb_top from the bench top file
//----------------------------------------------------------------------
`timescale 1ns/10ps
module cpb_top_assertions #(
   parameter logic [7:0] DEVICE_CODE   = 8'hA5,
   parameter logic [7:0] REVISION_CODE = 8'h03
) (
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire logic                 hard_rst,
   input wire logic                 cfg_state,
   input wire cpb_pkg::cpb_io_req_t io_req,
   input wire logic                 fir_mode_wr,
   input wire logic [2:0]           fir_mode,
   input wire logic [7:0]           io_rdata,
   input wire logic                 io_rvalid,
   input wire logic [10:0]          cfg_port_base,
   input wire logic [2:0]           uart2_mode,
   input wire logic                 ir_alt_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic       hit, rd_data, wr_data;
   logic [7:0] idx_q;
   logic [2:0] quiet_q;
   // Port hit in config state
   assign hit = cfg_state && !hard_rst && (io_req.addr[15:11] == 5'h00)
                && (io_req.addr[10:1] == cfg_port_base[10:1]);
   assign rd_data = hit && io_req.rd && io_req.addr[0];
   assign wr_data = hit && io_req.wr && io_req.addr[0];
   // Shadow of the index and cycles since any reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         idx_q   <= 8'h00;
         quiet_q <= 3'h0;
      end else if (hard_rst) begin
         idx_q   <= 8'h00;
         quiet_q <= 3'h0;
      end else begin
         if (hit && io_req.wr && !io_req.addr[0]) idx_q <= io_req.wdata;
         if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
      end
   end
   sequence s_rd(logic [7:0] i);
      rd_data && (idx_q == i);
   endsequence
   sequence s_wr(logic [7:0] i);
      wr_data && (idx_q == i);
   endsequence
   a_read_answer: assert property (hit && io_req.rd |=> io_rvalid)
      else $error("read hit gave no valid");
   a_no_stray: assert property (io_rvalid |-> $past(hit && io_req.rd))
      else $error("valid without accepted read");
   a_id_fixed: assert property (s_rd(8'h0D) |=> io_rdata == DEVICE_CODE)
      else $error("identity read wrong");
   a_rev_fixed: assert property (s_rd(8'h0E) |=> io_rdata == REVISION_CODE)
      else $error("revision read wrong");
   a_low_even: assert property (s_rd(8'h12) |=> !io_rdata[0])
      else $error("low base bit 0 set");
   a_high_rsvd: assert property (s_rd(8'h13) |=> io_rdata[7:3] == 5'h00)
      else $error("high base reserved bits set");
   a_high_switch: assert property (s_wr(8'h13) |=>
      cfg_port_base[10:8] == $past(io_req.wdata[2:0]))
      else $error("high base write did not move decoder");
   a_base_hold: assert property (quiet_q == 3'h7 &&
      !$past(wr_data && idx_q == 8'h13) |-> $stable(cfg_port_base))
      else $error("base moved without high write");
   a_even_base: assert property (!cfg_port_base[0])
      else $error("decoder base odd");
   a_alt_mode: assert property (ir_alt_mode == (uart2_mode == 3'h3 || uart2_mode[2]))
      else $error("alternate mode flag wrong");
   a_fir_load: assert property (fir_mode_wr && !hard_rst &&
      !(wr_data && idx_q == 8'h0C) |=> uart2_mode == $past(fir_mode))
      else $error("engine mode load missed");
endmodule : cpb_top_assertions

//--- tb/cpb_host_model.sv
//----------------------------------------------------------------------
// Purpose : Host side of the index and data configuration ports
// Assumes : One request per edge, read answer right after the taking edge
// Notes   : Idle cycles drive an inverted, missing address
//----------------------------------------------------------------------
`timescale 1ns/10ps
module cpb_host_model (
   input  wire logic            ref_clk,
   input  wire logic [7:0]      io_rdata,
   input  wire logic            io_rvalid,
   output cpb_pkg::cpb_io_req_t io_req
);
   initial io_req = '0;
   // One bus cycle launched after an edge
   task automatic drive(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
      @(posedge ref_clk);
      io_req <= '{addr: a, wdata: d, wr: w, rd: r};
   endtask : drive
   // Index write then data write
   task automatic cfg_wr(input logic [15:0] b, input logic [7:0] i, input logic [7:0] d);
      drive(b, i, 1'b1, 1'b0);
      drive(b + 16'h0001, d, 1'b1, 1'b0);
      drive(~b, ~d, 1'b0, 1'b0);
      // Let the taking edge settle before anyone looks at outputs
      #1;
   endtask : cfg_wr
   // Index write then data read, answer taken after the taking edge
   task automatic cfg_rd(input logic [15:0] b, input logic [7:0] i,
                         output logic [7:0] d, output logic v);
      drive(b, i, 1'b1, 1'b0);
      drive(b + 16'h0001, ~i, 1'b0, 1'b1);
      drive(~b, i, 1'b0, 1'b0);
      #1;
      d = io_rdata;
      v = io_rvalid;
   endtask : cfg_rd
   // Low byte first, high bits after
   task automatic relocate(input logic [15:0] b, input logic [7:0] lo, input logic [7:0] hi);
      cfg_wr(b, 8'h12, lo);
      cfg_wr(b, 8'h13, hi);
   endtask : relocate
endmodule : cpb_host_model

//--- tb/tb_config_port_base_and_id_regs.sv
//----------------------------------------------------------------------
// Purpose : Self checking bench of the config port register group
// Assumes : Strap held steady around each reset
// Notes   : Identity codes below are arbitrary
//----------------------------------------------------------------------
`timescale 1ns/10ps
module tb_config_port_base_and_id_regs;
   typedef struct packed { logic [7:0] idx; logic [7:0] wd; logic [7:0] exp; } cpb_tb_row_t;
   localparam logic [7:0] DEV = 8'h6C; // Arbitrary value
   localparam logic [7:0] REV = 8'h21; // Arbitrary value
   logic ref_clk, nrst, hard_rst, cfg_state, strap, fir_mode_wr, io_rvalid, ir_alt_mode, v;
   logic [2:0]  fir_mode, uart2_mode;
   logic [7:0]  io_rdata, d;
   logic [10:0] cfg_port_base;
   cpb_pkg::cpb_io_req_t io_req;
   int failures, total_checks;
   cpb_tb_row_t rows [8] = '{'{8'h0D, 8'hFF, DEV}, '{8'h0E, 8'hFF, REV},
      '{8'h0F, 8'h55, 8'h55}, '{8'h10, 8'hAA, 8'hAA}, '{8'h11, 8'h3C, 8'h3C},
      '{8'h0C, 8'h1A, 8'h1A}, '{8'h20, 8'h77, 8'h00}, '{8'h12, 8'h81, 8'h80}};
   cpb_top #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
      .hard_rst(hard_rst), .cfg_state(cfg_state), .base_address_strap(strap),
      .io_req(io_req), .fir_mode_wr(fir_mode_wr), .fir_mode(fir_mode), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .cfg_port_base(cfg_port_base), .uart2_mode(uart2_mode),
      .ir_alt_mode(ir_alt_mode));
   cpb_host_model u_host (.ref_clk(ref_clk), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .io_req(io_req));
   // Compare and count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd_chk(input logic [15:0] b, input logic [7:0] i, input logic [7:0] e);
      u_host.cfg_rd(b, i, d, v);
      chk("rvalid", 16'h0001, {15'h0000, v});
      chk("rdata", {8'h00, e}, {8'h00, d});
   endtask : rd_chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic por;
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask : por
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      report_and_stop;
   end
   initial begin
      {hard_rst, strap, fir_mode_wr, fir_mode} = '0;
      cfg_state = 1'b1;
      nrst = 1'b0;
      por();
      // Table of register accesses at the strap 0 base
      foreach (rows[k]) begin
         u_host.cfg_wr(16'h002E, rows[k].idx, rows[k].wd);
         rd_chk(16'h002E, rows[k].idx, rows[k].exp);
      end
      chk("base after low write", 16'h002E, {5'h00, cfg_port_base});
      $display("test table done");
      // Strap must pass the synchroniser before the hard reset samples it
      strap <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(posedge ref_clk) hard_rst <= 1'b1;
      @(posedge ref_clk) hard_rst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("base hard reset", 16'h004E, {5'h00, cfg_port_base});
      rd_chk(16'h004E, 8'h13, 8'h00);
      rd_chk(16'h004E, 8'h0F, 8'h55);
      u_host.relocate(16'h004E, 8'h61, 8'hFD);
      chk("base moved", 16'h0560, {5'h00, cfg_port_base});
      rd_chk(16'h0560, 8'h13, 8'h05);
      $display("test relocate done");
      u_host.cfg_rd(16'h0D60, 8'h0D, d, v);
      chk("rvalid high bits", 16'h0000, {15'h0000, v});
      cfg_state <= 1'b0;
      u_host.cfg_rd(16'h0560, 8'h0D, d, v);
      chk("rvalid outside config", 16'h0000, {15'h0000, v});
      cfg_state <= 1'b1;
      $display("test refusals done");
      @(posedge ref_clk) {fir_mode_wr, fir_mode} <= 4'hC;
      @(posedge ref_clk) fir_mode_wr <= 1'b0;
      #1;
      chk("uart2 mode", 16'h0004, {13'h0000, uart2_mode});
      chk("alt mode", 16'h0001, {15'h0000, ir_alt_mode});
      $display("test engine mode done");
      por();
      chk("base power on", 16'h004E, {5'h00, cfg_port_base});
      for (int i = 0; i < 3; i++) rd_chk(16'h004E, 8'h0F + i[7:0], 8'h00);
      $display("test power on done");
      report_and_stop;
   end
endmodule : tb_config_port_base_and_id_regs
bind cpb_top cpb_top_assertions #(.DEVICE_CODE(DEVICE_CODE), .REVISION_CODE(REVISION_CODE))
   u_chk (.ref_clk(ref_clk), .nrst(nrst), .hard_rst(hard_rst), .cfg_state(cfg_state),
   .io_req(io_req), .fir_mode_wr(fir_mode_wr), .fir_mode(fir_mode), .io_rdata(io_rdata),
   .io_rvalid(io_rvalid), .cfg_port_base(cfg_port_base), .uart2_mode(uart2_mode),
   .ir_alt_mode(ir_alt_mode));
